// file: verilog/load_monitor.sv
`timescale 1ns/100ps
// Notes on behaviour
// - Low trip threshold holds 0..200 percent, reset value 84.
// - Power below low trip threshold starts its delay, then raises the alarm.
// - Alarm only after violation lasts continuously longer than delay, 0.1..90 s, default 0.5.
// - After run command all alarms are held off for start delay, 1..999 s, default 10.
// - Successful autoset captures present power as normal load reference.
// - Autoset: high trip threshold is reference plus high trip margin, default 16.
// - Autoset: high warn threshold is reference plus high warn margin, default 8.
// - Autoset: low warn threshold is reference minus low warn margin, default 8.
// - Autoset: low trip threshold is reference minus low trip margin, default 16.
// - Writing a margin never changes active thresholds; only autoset applies them.
// - Manual threshold write turns the normal load reference off.
// - Autoset fails unless motor runs and start delay finished; else succeeds.
// - Autoset digital input triggers on its rising edge, never on level.
// - Each new autoset replaces all thresholds, manual or earlier autoset.
// - Normal load is read-only: off, or 0..200 captured at last autoset.
// - Same action and delay settings apply to manual and autoset thresholds.
// - Action codes: none 0, hard trip 1, soft trip 3, warning 4; default none.
// - Power above high trip threshold for its delay raises the configured action.
module load_monitor
  import load_monitor_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_CYCLES_DFLT
) (
  input  logic              clk_sys,
  input  logic              arst_n,
  input  logic              psel,
  input  logic              penable,
  input  logic              pwrite,
  input  logic [ADDR_W-1:0] paddr,
  input  logic [31:0]       pwdata,
  output logic [31:0]       prdata,
  output logic              pready,
  output logic              pslverr,
  input  logic [TH_W-1:0]   shaft_power,
  input  logic              motor_running,
  input  logic              autoset_din,
  output logic [NUM_CH-1:0] alarm_active,
  output logic              trip_hard,
  output logic              trip_soft,
  output logic              warning
);

  logic                run_s1;
  logic                run_s2;
  logic                din_s1;
  logic                din_s2;
  logic                din_s3;
  logic [TICK_W-1:0]   tick_cnt;
  logic                tick;
  start_state_t        sd_state;
  logic [SDC_W-1:0]    sd_cnt;
  logic [SDC_W-1:0]    sd_target;
  logic                sd_done;
  logic [TH_W-1:0]     thr [NUM_CH];
  logic [MAR_W-1:0]    margin [NUM_CH];
  logic [DEL_W-1:0]    delay [NUM_CH];
  alarm_action_t       action [NUM_CH];
  logic [SD_W-1:0]     start_delay;
  logic                din_en;
  logic [TH_W-1:0]     normal_load;
  logic                normal_off;
  logic                as_ok;
  logic                as_fail;
  logic [TH_W-1:0]     pwr_c;
  logic [TH_W-1:0]     exp_thr [NUM_CH];
  logic                wr;
  logic                menu_trig;
  logic                din_trig;
  logic                trig;
  logic                as_ready;
  logic [NUM_CH-1:0]   wr_thr;
  logic [NUM_CH-1:0]   wr_mar;
  logic [NUM_CH-1:0]   wr_del;
  logic [NUM_CH-1:0]   wr_act;
  logic [31:0]         rd_word;
  logic                rd_hit;
  logic [NUM_CH-1:0]   ch_alarm;
  logic                next_hard;
  logic                next_soft;
  logic                next_warn;

  function automatic logic [TH_W-1:0] clamp_pct(input logic [31:0] v);
    return (v > 32'(PCT_MAX)) ? PCT_MAX : v[TH_W-1:0];
  endfunction

  function automatic logic [TH_W-1:0] sat_add(input logic [TH_W-1:0] p, input logic [MAR_W-1:0] m);
    logic [TH_W:0] s;
    s = {1'b0, p} + {2'b00, m};
    return (s > {1'b0, PCT_MAX}) ? PCT_MAX : s[TH_W-1:0];
  endfunction

  function automatic logic [TH_W-1:0] sat_sub(input logic [TH_W-1:0] p, input logic [MAR_W-1:0] m);
    return ({1'b0, m} > p) ? 8'h00 : p - {1'b0, m};
  endfunction

  // Pins from outside, two flip-flops before use
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      run_s1 <= 1'b0;
      run_s2 <= 1'b0;
      din_s1 <= 1'b0;
      din_s2 <= 1'b0;
      din_s3 <= 1'b0;
    end else begin
      run_s1 <= motor_running;
      run_s2 <= run_s1;
      din_s1 <= autoset_din;
      din_s2 <= din_s1;
      din_s3 <= din_s2;
    end
  end

  // One pulse per tenth of a second
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      tick_cnt <= '0;
    end else if (tick) begin
      tick_cnt <= '0;
    end else begin
      tick_cnt <= tick_cnt + 22'h000001;
    end
  end
  assign tick = (tick_cnt == TICK_W'(TICK_CYCLES - 1));

  // Start delay: run command is the rising edge of the running level
  assign sd_target = {4'h0, start_delay} * TENTHS_PER_S;
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      sd_state <= SD_IDLE;
      sd_cnt   <= '0;
    end else if (!run_s2) begin
      sd_state <= SD_IDLE;
      sd_cnt   <= '0;
    end else begin
      unique case (sd_state)
        SD_IDLE: begin
          sd_state <= SD_COUNT;
          sd_cnt   <= '0;
        end
        SD_COUNT: begin
          if (sd_cnt >= sd_target) begin
            sd_state <= SD_DONE;
          end else if (tick) begin
            sd_cnt <= sd_cnt + 14'h0001;
          end
        end
        SD_DONE: begin
          sd_state <= SD_DONE;
        end
      endcase
    end
  end
  assign sd_done = (sd_state == SD_DONE);

  // APB: zero wait states, read data captured in the setup cycle
  assign pready    = 1'b1;
  assign wr        = psel && penable && pwrite;
  assign menu_trig = wr && paddr == OFS_CTRL && pwdata[CTRL_AUTOSET_BIT] == AUTOSET_YES;
  assign din_trig  = din_en && din_s2 && !din_s3;
  assign trig      = menu_trig || din_trig;
  assign as_ready  = run_s2 && sd_done;
  assign pwr_c     = clamp_pct(32'(shaft_power));

  always_comb begin
    rd_hit  = 1'b1;
    rd_word = '0;
    wr_thr  = '0;
    wr_mar  = '0;
    wr_del  = '0;
    wr_act  = '0;
    unique case (paddr)
      OFS_CTRL:   rd_word[CTRL_DIN_EN_BIT] = din_en;
      OFS_STATUS: rd_word = {23'h0, normal_off, ch_alarm, run_s2, sd_done, as_fail, as_ok};
      OFS_NORMAL: rd_word = {23'h0, normal_off, normal_load};
      OFS_START:  rd_word = {22'h0, start_delay};
      default:    rd_hit = 1'b0;
    endcase
    for (int i = 0; i < NUM_CH; i++) begin
      if (paddr == OFS_THR_BASE + ADDR_W'(4 * i)) begin
        rd_hit    = 1'b1;
        rd_word   = {24'h0, thr[i]};
        wr_thr[i] = wr;
      end
      if (paddr == OFS_MAR_BASE + ADDR_W'(4 * i)) begin
        rd_hit    = 1'b1;
        rd_word   = {25'h0, margin[i]};
        wr_mar[i] = wr;
      end
      if (paddr == OFS_DEL_BASE + ADDR_W'(4 * i)) begin
        rd_hit    = 1'b1;
        rd_word   = {22'h0, delay[i]};
        wr_del[i] = wr;
      end
      if (paddr == OFS_ACT_BASE + ADDR_W'(4 * i)) begin
        rd_hit    = 1'b1;
        rd_word   = {29'h0, action[i]};
        wr_act[i] = wr;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      prdata  <= '0;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      prdata  <= pwrite ? 32'h0 : rd_word;
      pslverr <= !rd_hit;
    end
  end

  // Settings that do not touch active thresholds
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      margin[CH_HIGH_TRIP] <= HIGH_TRIP_MAR_RST;
      margin[CH_HIGH_WARN] <= HIGH_WARN_MAR_RST;
      margin[CH_LOW_WARN]  <= LOW_WARN_MAR_RST;
      margin[CH_LOW_TRIP]  <= LOW_TRIP_MAR_RST;
      for (int i = 0; i < NUM_CH; i++) begin
        delay[i]  <= DELAY_RST;
        action[i] <= ACT_NONE;
      end
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (wr_mar[i]) begin
          margin[i] <= (pwdata > 32'(MAR_MAX)) ? MAR_MAX : pwdata[MAR_W-1:0];
        end
        if (wr_del[i]) begin
          delay[i] <= (pwdata < 32'(DEL_MIN)) ? DEL_MIN :
                      (pwdata > 32'(DEL_MAX)) ? DEL_MAX : pwdata[DEL_W-1:0];
        end
        if (wr_act[i]) begin
          unique case (pwdata[2:0])
            ACT_HARD: action[i] <= ACT_HARD;
            ACT_SOFT: action[i] <= ACT_SOFT;
            ACT_WARN: action[i] <= ACT_WARN;
            default:  action[i] <= ACT_NONE;
          endcase
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      start_delay <= START_DELAY_RST;
      din_en      <= 1'b0;
    end else begin
      if (wr && paddr == OFS_START) begin
        start_delay <= (pwdata < 32'(SD_MIN)) ? SD_MIN :
                       (pwdata > 32'(SD_MAX)) ? SD_MAX : pwdata[SD_W-1:0];
      end
      if (wr && paddr == OFS_CTRL) begin
        din_en <= pwdata[CTRL_DIN_EN_BIT];
      end
    end
  end

  // Autoset targets, saturated into range
  assign exp_thr[CH_HIGH_TRIP] = sat_add(pwr_c, margin[CH_HIGH_TRIP]);
  assign exp_thr[CH_HIGH_WARN] = sat_add(pwr_c, margin[CH_HIGH_WARN]);
  assign exp_thr[CH_LOW_WARN]  = sat_sub(pwr_c, margin[CH_LOW_WARN]);
  assign exp_thr[CH_LOW_TRIP]  = sat_sub(pwr_c, margin[CH_LOW_TRIP]);

  // A good autoset beats a manual write landing in the same cycle
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      thr[CH_HIGH_TRIP] <= HIGH_TRIP_THR_RST;
      thr[CH_HIGH_WARN] <= HIGH_WARN_THR_RST;
      thr[CH_LOW_WARN]  <= LOW_WARN_THR_RST;
      thr[CH_LOW_TRIP]  <= LOW_TRIP_THR_RST;
    end else if (trig && as_ready) begin
      for (int i = 0; i < NUM_CH; i++) begin
        thr[i] <= exp_thr[i];
      end
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (wr_thr[i]) begin
          thr[i] <= clamp_pct(pwdata);
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      normal_load <= '0;
      normal_off  <= 1'b1;
    end else if (trig && as_ready) begin
      normal_load <= pwr_c;
      normal_off  <= 1'b0;
    end else if (|wr_thr) begin
      normal_off  <= 1'b1;
    end
  end

  // Result flags: a new attempt wins over a write-one clear
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      as_ok   <= 1'b0;
      as_fail <= 1'b0;
    end else if (trig) begin
      as_ok   <= as_ready;
      as_fail <= !as_ready;
    end else if (wr && paddr == OFS_STATUS) begin
      if (pwdata[ST_OK_BIT]) begin
        as_ok <= 1'b0;
      end
      if (pwdata[ST_FAIL_BIT]) begin
        as_fail <= 1'b0;
      end
    end
  end

  generate
    for (genvar g = 0; g < NUM_CH; g++) begin : g_chan
      alarm_chan_if chif ();
      assign chif.power     = pwr_c;
      assign chif.threshold = thr[g];
      assign chif.delay     = delay[g];
      assign chif.above     = (g < CH_LOW_WARN);
      assign chif.arm       = run_s2 && sd_done;
      assign chif.tick      = tick;
      assign ch_alarm[g]    = chif.alarm;
      alarm_channel u_chan (
        .clk_sys (clk_sys),
        .arst_n  (arst_n),
        .ch      (chif)
      );
    end
  endgenerate

  always_comb begin
    next_hard = 1'b0;
    next_soft = 1'b0;
    next_warn = 1'b0;
    for (int i = 0; i < NUM_CH; i++) begin
      next_hard = next_hard || (ch_alarm[i] && action[i] == ACT_HARD);
      next_soft = next_soft || (ch_alarm[i] && action[i] == ACT_SOFT);
      next_warn = next_warn || (ch_alarm[i] && action[i] == ACT_WARN);
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      alarm_active <= '0;
      trip_hard    <= 1'b0;
      trip_soft    <= 1'b0;
      warning      <= 1'b0;
    end else begin
      alarm_active <= ch_alarm;
      trip_hard    <= next_hard;
      trip_soft    <= next_soft;
      warning      <= next_warn;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  property p_start_hold;
    !sd_done ##1 !sd_done |-> ch_alarm == '0;
  endproperty
  a_start_hold: assert property (p_start_hold) else $error("alarm during start delay");

  property p_fail;
    trig && !as_ready && !(|wr_thr) |=> as_fail && !as_ok && $stable(thr[CH_LOW_TRIP]) && $stable(normal_off);
  endproperty
  a_fail: assert property (p_fail) else $error("autoset not refused");

  property p_capture;
    trig && as_ready |=> normal_load == $past(pwr_c) && !normal_off && as_ok;
  endproperty
  a_capture: assert property (p_capture) else $error("reference not captured");

  property p_high_trip;
    trig && as_ready |=> thr[CH_HIGH_TRIP] == $past(exp_thr[CH_HIGH_TRIP]);
  endproperty
  a_high_trip: assert property (p_high_trip) else $error("high trip threshold wrong");

  property p_high_warn;
    trig && as_ready |=> thr[CH_HIGH_WARN] >= normal_load && thr[CH_HIGH_WARN] == $past(exp_thr[CH_HIGH_WARN]);
  endproperty
  a_high_warn: assert property (p_high_warn) else $error("high warn threshold wrong");

  property p_low_warn;
    trig && as_ready |=> thr[CH_LOW_WARN] <= normal_load && thr[CH_LOW_WARN] == $past(exp_thr[CH_LOW_WARN]);
  endproperty
  a_low_warn: assert property (p_low_warn) else $error("low warn threshold wrong");

  property p_low_trip;
    trig && as_ready |=> thr[CH_LOW_TRIP] == $past(exp_thr[CH_LOW_TRIP]);
  endproperty
  a_low_trip: assert property (p_low_trip) else $error("low trip threshold wrong");

  property p_margin;
    (|wr_mar) && !trig && !(|wr_thr) |=> $stable(thr[CH_HIGH_TRIP]) && $stable(thr[CH_LOW_TRIP]);
  endproperty
  a_margin: assert property (p_margin) else $error("margin write moved a threshold");

  property p_manual;
    (|wr_thr) && !(trig && as_ready) |=> normal_off;
  endproperty
  a_manual: assert property (p_manual) else $error("reference not turned off");

  property p_range;
    thr[CH_HIGH_TRIP] <= PCT_MAX && thr[CH_HIGH_WARN] <= PCT_MAX && normal_load <= PCT_MAX;
  endproperty
  a_range: assert property (p_range) else $error("threshold out of range");

  property p_din_level;
    din_s2 && din_s3 |-> !din_trig;
  endproperty
  a_din_level: assert property (p_din_level) else $error("level retriggered autoset");

  property p_action;
    ch_alarm[CH_LOW_TRIP] && action[CH_LOW_TRIP] == ACT_HARD |=> trip_hard;
  endproperty
  a_action: assert property (p_action) else $error("hard trip not raised");

  c_autoset_ok:   cover property (trig && as_ready);
  c_autoset_fail: cover property (trig && !as_ready);
  c_manual_write: cover property (|wr_thr ##1 normal_off);
  c_warn_out:     cover property ($rose(warning));

endmodule // load_monitor

// file: verilog/load_monitor_pkg.sv
package load_monitor_pkg;

  localparam int NUM_CH  = 4;
  localparam int ADDR_W  = 8;
  localparam int TH_W    = 8;
  localparam int MAR_W   = 7;
  localparam int DEL_W   = 10;
  localparam int SD_W    = 10;
  localparam int SDC_W   = 14;
  localparam int TICK_W  = 22;

  localparam int CH_HIGH_TRIP = 0;
  localparam int CH_HIGH_WARN = 1;
  localparam int CH_LOW_WARN  = 2;
  localparam int CH_LOW_TRIP  = 3;

  localparam logic [TH_W-1:0]  PCT_MAX  = 8'hc8;
  localparam logic [MAR_W-1:0] MAR_MAX  = 7'h64;
  localparam logic [DEL_W-1:0] DEL_MIN  = 10'h001;
  localparam logic [DEL_W-1:0] DEL_MAX  = 10'h384;
  localparam logic [SD_W-1:0]  SD_MIN   = 10'h001;
  localparam logic [SD_W-1:0]  SD_MAX   = 10'h3e7;

  localparam logic [TH_W-1:0]  HIGH_TRIP_THR_RST = 8'h74;
  localparam logic [TH_W-1:0]  HIGH_WARN_THR_RST = 8'h6c;
  localparam logic [TH_W-1:0]  LOW_WARN_THR_RST  = 8'h5c;
  localparam logic [TH_W-1:0]  LOW_TRIP_THR_RST  = 8'h54;
  localparam logic [MAR_W-1:0] HIGH_TRIP_MAR_RST = 7'h10;
  localparam logic [MAR_W-1:0] HIGH_WARN_MAR_RST = 7'h08;
  localparam logic [MAR_W-1:0] LOW_WARN_MAR_RST  = 7'h08;
  localparam logic [MAR_W-1:0] LOW_TRIP_MAR_RST  = 7'h10;
  localparam logic [DEL_W-1:0] DELAY_RST         = 10'h005;
  localparam logic [SD_W-1:0]  START_DELAY_RST   = 10'h00a;

  // Time base: all delays count tenths of a second
  localparam int unsigned CLK_PERIOD_NS    = 40;
  localparam int unsigned TENTH_NS         = 100_000_000;
  localparam int unsigned TICK_CYCLES_DFLT = TENTH_NS / CLK_PERIOD_NS;
  localparam logic [SDC_W-1:0] TENTHS_PER_S = 14'h00a;

  localparam logic [ADDR_W-1:0] OFS_CTRL     = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_STATUS   = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_NORMAL   = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_THR_BASE = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_MAR_BASE = 8'h1c;
  localparam logic [ADDR_W-1:0] OFS_DEL_BASE = 8'h2c;
  localparam logic [ADDR_W-1:0] OFS_ACT_BASE = 8'h3c;
  localparam logic [ADDR_W-1:0] OFS_START    = 8'h4c;

  localparam int CTRL_AUTOSET_BIT = 0;
  localparam int CTRL_DIN_EN_BIT  = 1;
  localparam int ST_OK_BIT        = 0;
  localparam int ST_FAIL_BIT      = 1;
  localparam int ST_DONE_BIT      = 2;
  localparam int ST_RUN_BIT       = 3;
  localparam int ST_ALARM_LSB     = 4;
  localparam int ST_NL_OFF_BIT    = 8;
  localparam int NL_OFF_BIT       = 8;

  localparam logic AUTOSET_NO  = 1'b0;
  localparam logic AUTOSET_YES = 1'b1;

  typedef enum logic [2:0] {
    ACT_NONE = 3'h0,
    ACT_HARD = 3'h1,
    ACT_SOFT = 3'h3,
    ACT_WARN = 3'h4
  } alarm_action_t;

  typedef enum logic [2:0] {
    SD_IDLE  = 3'b001,
    SD_COUNT = 3'b010,
    SD_DONE  = 3'b100
  } start_state_t;

endpackage

// file: verilog/alarm_chan_if.sv
`timescale 1ns/100ps
interface alarm_chan_if;
  import load_monitor_pkg::*;
  logic [TH_W-1:0]  power;
  logic [TH_W-1:0]  threshold;
  logic [DEL_W-1:0] delay;
  logic             above;
  logic             arm;
  logic             tick;
  logic             alarm;
  modport ctrl (output power, threshold, delay, above, arm, tick, input alarm);
  modport chan (input power, threshold, delay, above, arm, tick, output alarm);
endinterface

// file: verilog/alarm_channel.sv
`timescale 1ns/100ps
module alarm_channel
  import load_monitor_pkg::*;
(
  input logic          clk_sys,
  input logic          arst_n,
  alarm_chan_if.chan   ch
);

  logic             violate;
  logic [DEL_W-1:0] cnt;
  logic             alarm;

  assign violate = ch.arm && (ch.above ? (ch.power > ch.threshold) : (ch.power < ch.threshold));

  // Tick phase is unknown, so one extra tick guarantees strictly longer than the delay
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cnt <= '0;
    end else if (!violate) begin
      cnt <= '0;
    end else if (ch.tick && cnt <= ch.delay) begin
      cnt <= cnt + 10'h001;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      alarm <= 1'b0;
    end else if (!violate) begin
      alarm <= 1'b0;
    end else if (cnt > ch.delay) begin
      alarm <= 1'b1;
    end
  end

  assign ch.alarm = alarm;

  property p_no_early;
    @(posedge clk_sys) disable iff (!arst_n) $rose(alarm) |-> $past(cnt) > $past(ch.delay);
  endproperty
  a_no_early: assert property (p_no_early) else $error("alarm raised before delay ran out");

  property p_drop;
    @(posedge clk_sys) disable iff (!arst_n) !violate |=> !alarm && cnt == '0;
  endproperty
  a_drop: assert property (p_drop) else $error("alarm or count kept after violation ended");

  property p_raise;
    @(posedge clk_sys) disable iff (!arst_n) violate && cnt > ch.delay ##1 violate |=> alarm;
  endproperty
  a_raise: assert property (p_raise) else $error("alarm not raised after delay");

  c_alarm: cover property (@(posedge clk_sys) disable iff (!arst_n) $rose(alarm));

endmodule // alarm_channel

// file: verification/load_source.sv
`timescale 1ns/100ps
// Far side: measured power, run pin and the autoset input pin
module load_source
  import load_monitor_pkg::*;
(
  input  logic            clk_sys,
  input  logic [TH_W-1:0] power_req,
  input  logic            run_req,
  input  logic            din_req,
  output logic [TH_W-1:0] shaft_power,
  output logic            motor_running,
  output logic            autoset_din
);
  // Pins move only just after an edge, like a sampled sensor
  always_ff @(posedge clk_sys) begin
    shaft_power   <= power_req;
    motor_running <= run_req;
    autoset_din   <= din_req;
  end
endmodule // load_source

// file: verification/load_monitor_tb_top.sv
`timescale 1ns/100ps
module load_monitor_tb_top;
  import load_monitor_pkg::*;
  logic              clk_sys = 1'b0;
  logic              arst_n = 1'b0;
  logic              psel = 1'b0;
  logic              penable = 1'b0;
  logic              pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = 8'h00;
  logic [31:0]       pwdata = 32'h0;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic [TH_W-1:0]   power_req = 8'h64;
  logic              run_req = 1'b0;
  logic              din_req = 1'b0;
  logic [TH_W-1:0]   shaft_power;
  logic              motor_running;
  logic              autoset_din;
  logic [NUM_CH-1:0] alarm_active;
  logic              trip_hard;
  logic              trip_soft;
  logic              warning;
  logic              last_err;
  logic [31:0]       q;
  int                n_errors = 0;
  int                compares = 0;
  int                n;
  // Reset values: thresholds, margins, one delay, normal load, start delay
  logic [7:0]  row_addr [11] = '{8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20, 8'h24, 8'h28, 8'h2c, 8'h08, 8'h4c};
  logic [31:0] row_exp [11] = '{32'h74, 32'h6c, 32'h5c, 32'h54, 32'h10, 32'h08, 32'h08, 32'h10, 32'h05,
                                32'h100, 32'h0a};

  always #20 clk_sys = ~clk_sys;

  // Short tick so the 0.1 s time base costs four clocks
  load_monitor #(.TICK_CYCLES(4)) dut_u (.clk_sys(clk_sys), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .shaft_power(shaft_power), .motor_running(motor_running), .autoset_din(autoset_din),
    .alarm_active(alarm_active), .trip_hard(trip_hard), .trip_soft(trip_soft), .warning(warning));

  load_source src_u (.clk_sys(clk_sys), .power_req(power_req), .run_req(run_req), .din_req(din_req),
    .shaft_power(shaft_power), .motor_running(motor_running), .autoset_din(autoset_din));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    // No wait-state count assumed; the watchdog ends a hang
    do @(posedge clk_sys); while (pready !== 1'b1);
    q        = prdata;
    last_err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(q, exp);
  endtask

  task automatic thr4(input logic [31:0] a, input logic [31:0] b, input logic [31:0] c, input logic [31:0] d);
    rd(OFS_THR_BASE, a);
    rd(OFS_THR_BASE + 8'h04, b);
    rd(OFS_THR_BASE + 8'h08, c);
    rd(OFS_THR_BASE + 8'h0c, d);
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_sys);
    n_errors++;
    conclude();
  end

  initial begin
    repeat (20) @(posedge clk_sys);
    arst_n <= 1'b1;
    for (int i = 0; i < 11; i++) begin
      rd(row_addr[i], row_exp[i]);
    end
    apb(1'b1, OFS_START, 32'h1);
    apb(1'b1, OFS_ACT_BASE + 8'h0c, 32'h1);
    apb(1'b1, OFS_ACT_BASE + 8'h08, 32'h4);
    apb(1'b1, OFS_CTRL, 32'h1);
    rd(OFS_STATUS, 32'h102);
    thr4(32'h74, 32'h6c, 32'h5c, 32'h54);
    power_req <= 8'h32;
    run_req   <= 1'b1;
    n = 0;
    // Underload from the first cycle, so the start delay alone holds it off
    do begin
      apb(1'b0, OFS_STATUS, 32'h0);
      chk({28'h0, alarm_active}, 32'h0);
      n++;
    end while (q[ST_DONE_BIT] !== 1'b1 && n < 200);
    chk({31'h0, q[ST_DONE_BIT]}, 32'h1);
    n = 0;
    while (alarm_active[CH_LOW_TRIP] !== 1'b1 && n < 200) begin
      @(posedge clk_sys);
      n++;
    end
    chk(32'(n >= 16), 32'h1);
    repeat (3) @(posedge clk_sys);
    chk({alarm_active, trip_hard, trip_soft, warning}, 7'b1100101);
    power_req <= 8'h69;
    repeat (10) @(posedge clk_sys);
    chk({28'h0, alarm_active}, 32'h0);
    apb(1'b1, OFS_MAR_BASE, 32'h14);
    rd(OFS_THR_BASE, 32'h74);
    apb(1'b1, OFS_CTRL, 32'h1);
    thr4(32'h7d, 32'h71, 32'h61, 32'h59);
    rd(OFS_NORMAL, 32'h69);
    rd(OFS_STATUS, 32'h0d);
    apb(1'b1, OFS_THR_BASE + 8'h04, 32'h96);
    rd(OFS_NORMAL, 32'h169);
    power_req <= 8'hbe;
    apb(1'b1, OFS_CTRL, 32'h2);
    din_req <= 1'b1;
    repeat (8) @(posedge clk_sys);
    thr4(32'hc8, 32'hc6, 32'hb6, 32'hae);
    rd(OFS_NORMAL, 32'hbe);
    // Pin held high: a level must not start another capture
    power_req <= 8'h3c;
    repeat (8) @(posedge clk_sys);
    rd(OFS_NORMAL, 32'hbe);
    apb(1'b0, 8'h50, 32'h0);
    chk({31'h0, last_err}, 32'h1);
    apb(1'b1, OFS_DEL_BASE, 32'h0);
    rd(OFS_DEL_BASE, 32'h1);
    apb(1'b1, OFS_ACT_BASE + 8'h0c, 32'h3);
    rd(OFS_ACT_BASE + 8'h0c, 32'h3);
    apb(1'b1, OFS_ACT_BASE + 8'h04, 32'h2);
    rd(OFS_ACT_BASE + 8'h04, 32'h0);
    // Power far below both low thresholds: soft trip and warning now
    repeat (30) @(posedge clk_sys);
    chk({alarm_active, trip_hard, trip_soft, warning}, 7'b1100011);
    // Reset in mid-run with alarms standing
    arst_n <= 1'b0;
    @(posedge clk_sys);
    chk({alarm_active, trip_hard, trip_soft, warning}, 7'h00);
    arst_n <= 1'b1;
    thr4(32'h74, 32'h6c, 32'h5c, 32'h54);
    rd(OFS_NORMAL, 32'h100);
    rd(OFS_STATUS, 32'h108);
    conclude();
  end
endmodule // load_monitor_tb_top
